// *** testbench.sv ***
// Self-checking testbench of the trigger sequencer register set
`timescale 1ns/1ps
`include "tsq_cfg.svh"
module testbench;
  logic CORE_CLK;
  logic RESETN;
  logic [5:0] ADDR;
  logic [15:0] WDATA;
  logic WR_STB;
  logic RD_STB;
  logic [15:0] RDATA;
  tsq_pkg::tsq_fanout_t BCAST_PULSE;
  logic [31:0] TRIG_OUT;
  logic [5:0] ADC_CHANNEL_SEL;
  logic SEQ_BUSY;
  logic ev_valid;
  logic [53:0] ev_data;
  logic [53:0] exp_q[$];
  int gap_q[$];
  int failures;
  int n_compared;
  int cyc;
  int last_ev;
  logic [15:0] lfsr_r;
  logic [15:0] shadow [0:15];
  logic [15:0] v;
  logic [15:0] bte;
  logic [5:0] ch;

  tsq_regs #(.SEQ_DIV(1), .QUE_WORDS(16)) u_tsq_regs (
    .CORE_CLK(CORE_CLK),
    .RESETN(RESETN),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .WR_STB(WR_STB),
    .RD_STB(RD_STB),
    .RDATA(RDATA),
    .BCAST_PULSE(BCAST_PULSE),
    .TRIG_OUT(TRIG_OUT),
    .ADC_CHANNEL_SEL(ADC_CHANNEL_SEL),
    .SEQ_BUSY(SEQ_BUSY)
  );

  tsq_trig_sink u_tsq_trig_sink (
    .clk(CORE_CLK),
    .resetn(RESETN),
    .bcast(BCAST_PULSE),
    .trig(TRIG_OUT),
    .chsel(ADC_CHANNEL_SEL),
    .ev_valid(ev_valid),
    .ev_data(ev_data)
  );

  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [53:0] seen, input logic [53:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // An idle edge before each strobe keeps every signal to one assignment per step
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge CORE_CLK);
    WR_STB <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] want);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CORE_CLK);
    RD_STB <= 1'b0;
    #1;
    check({38'h0, RDATA}, {38'h0, want});
  endtask

  task automatic do_reset();
    @(posedge CORE_CLK);
    RESETN <= 1'b0;
    repeat (12) @(posedge CORE_CLK);
    RESETN <= 1'b1;
  endtask

  // ==========================================================
  // Clock and event monitor; sampled on the falling edge so outputs have settled
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end

  always @(negedge CORE_CLK) begin
    cyc = cyc + 1;
    if (ev_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("mismatch at %0t: unexpected trigger event %h", $time, ev_data);
      end else begin
        check(ev_data, exp_q.pop_front());
        if (gap_q[0] != 0) begin
          check(54'(cyc - last_ev), 54'(gap_q[0]));
        end
        void'(gap_q.pop_front());
      end
      last_ev = cyc;
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    RESETN = 1'b0;
    ADDR = 6'h00;
    WDATA = 16'h0000;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    failures = 0;
    n_compared = 0;
    cyc = 0;
    last_ev = 0;
    lfsr_r = 16'h0011;
    do_reset();
    for (int i = 1; i <= 10; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      wr(6'(i), lfsr_r);
      rd(6'(i), (6'(i) == `TSQ_A_QPTR) ? (lfsr_r & 16'h001f) : lfsr_r);
    end
    for (int i = 0; i < 16; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      shadow[i] = lfsr_r;
      wr(`TSQ_A_QUE0 + 6'(i), lfsr_r);
    end
    wr(6'h0b, 16'hffff);
    rd(6'h0b, 16'h0000);
    do_reset();
    for (int i = 1; i <= 10; i++) begin
      rd(6'(i), 16'h0000);
    end
    for (int i = 0; i < 16; i++) begin
      rd(`TSQ_A_QUE0 + 6'(i), shadow[i]);
    end
    // ========================================================
    // Program: copy, add, literal, broadcast, trigger loop on counter 0, timer wait, trigger, park
    lfsr_r = lfsr_next(lfsr_r);
    v = lfsr_r | 16'h0001;
    lfsr_r = lfsr_next(lfsr_r);
    bte = lfsr_r | 16'h0010;
    lfsr_r = lfsr_next(lfsr_r);
    ch = 6'(v + (lfsr_r & 16'hfffe));
    wr(`TSQ_A_LIT, v);
    wr(`TSQ_A_ADJ, lfsr_r & 16'hfffe);
    wr(`TSQ_A_HOLD, 16'h0001);
    wr(`TSQ_A_BTE, bte);
    wr(`TSQ_A_C0LIM, 16'h0002);
    wr(`TSQ_A_T0LIM, 16'h0002);
    wr(`TSQ_A_QUE0, 16'h151c);
    wr(`TSQ_A_QUE0 + 6'h01, 16'h0f0e);
    wr(`TSQ_A_QUE0 + 6'h02, 16'hc485);
    wr(`TSQ_A_QUE0 + 6'h03, 16'h9f08);
    wr(`TSQ_A_QUE0 + 6'h04, 16'h00a8);
    exp_q = '{{48'h0, ch}, {bte, 32'h00000000, ch}, {16'h0, 32'h00000020, ch},
              {16'h0, 32'h00000020, ch}, {16'h0, 32'h00000020, ch},
              {16'h0, 32'h80000000, ch}};
    gap_q = '{0, 2, 2, 4, 4, 9};
    wr(`TSQ_A_CTRL, 16'h8080);
    for (int k = 0; k < 400 && exp_q.size() != 0; k++) begin
      @(posedge CORE_CLK);
    end
    if (exp_q.size() != 0) begin
      failures++;
      $display("mismatch at %0t: trigger events missing", $time);
    end else begin
      wr(`TSQ_A_BTE, ~bte);
      rd(`TSQ_A_BTE, bte);
      wr(`TSQ_A_SDLIM, 16'h0005);
      rd(`TSQ_A_SDLIM, 16'h0001);
      wr(`TSQ_A_QUE0, 16'hffff);
      rd(`TSQ_A_QUE0, 16'h151c);
      wr(`TSQ_A_QPTR, 16'h0000);
      rd(`TSQ_A_QPTR, 16'h0008);
      check({53'h0, SEQ_BUSY}, 54'h1);
      wr(`TSQ_A_HOLD, 16'h1234);
      rd(`TSQ_A_HOLD, 16'h1234);
      wr(`TSQ_A_CTRL, 16'h0100);
      rd(`TSQ_A_C0LIM, 16'h0000);
      check({53'h0, SEQ_BUSY}, 54'h0);
      wr(`TSQ_A_T0LIM, 16'h0009);
      rd(`TSQ_A_T0LIM, 16'h0002);
      wr(`TSQ_A_CTRL, 16'h0000);
      rd(`TSQ_A_C0LIM, 16'h0002);
      rd(`TSQ_A_T0LIM, 16'h0009);
    end
    complete_run();
  end
endmodule // testbench

// *** tsq_cfg.svh ***
// Register map, field positions, reset values and command codes of the trigger sequencer
`ifndef TSQ_CFG_SVH
`define TSQ_CFG_SVH

// ==========================================================
// Register word addresses
`define TSQ_ADDR_W 6
`define TSQ_A_CTRL 6'h00
`define TSQ_A_BTE 6'h01
`define TSQ_A_T0LIM 6'h02
`define TSQ_A_T1LIM 6'h03
`define TSQ_A_SDLIM 6'h04
`define TSQ_A_C0LIM 6'h05
`define TSQ_A_C1LIM 6'h06
`define TSQ_A_HOLD 6'h07
`define TSQ_A_ADJ 6'h08
`define TSQ_A_LIT 6'h09
`define TSQ_A_QPTR 6'h0a
`define TSQ_A_QUE0 6'h10

// ==========================================================
// Control register fields
`define TSQ_CTRL_EN 15
`define TSQ_CTRL_VIS 8
`define TSQ_CTRL_RUN 7
`define TSQ_CTRL_MASK 16'h8180

// ==========================================================
// Reset values
`define TSQ_RST_REG 16'h0000
`define TSQ_RST_QPTR 5'h00
`define TSQ_RST_CHSEL 6'h00

// ==========================================================
// Limit slots, ordered as the add and copy options select them
`define TSQ_LIM_C0 3'h0
`define TSQ_LIM_C1 3'h1
`define TSQ_LIM_T0 3'h2
`define TSQ_LIM_T1 3'h3
`define TSQ_LIM_SD 3'h4
`define TSQ_LIM_LIT 3'h5

// ==========================================================
// Step command byte: opcode in bits 7-4, option in bits 3-0
`define TSQ_OP_CTRL 4'h0
`define TSQ_OP_ADDCOPY 4'h1
`define TSQ_OP_STRB 3'h1
`define TSQ_OP_TRIG 3'h4
`define TSQ_OP_JMP 3'h5
`define TSQ_OP_JMPC0 3'h6
`define TSQ_OP_JMPC1 3'h7
`define TSQ_OPT_SD_OFF 4'h2
`define TSQ_OPT_SD_ON 4'h6
`define TSQ_OPT_WAIT_T0 4'h8
`define TSQ_OPT_WAIT_T1 4'h9
`define TSQ_OPT_CH_C0 4'hc
`define TSQ_OPT_CH_C1 4'hd
`define TSQ_OPT_CH_LIT 4'he
`define TSQ_OPT_BCAST 4'hf

// ==========================================================
// Sequencer clock divider default
`define TSQ_SEQ_DIV 1

`endif

// *** tsq_pkg.sv ***
// Types shared by the trigger sequencer register set
package tsq_pkg;

  typedef enum logic [1:0] {
    TSQ_IDLE,
    TSQ_EXEC,
    TSQ_DELAY,
    TSQ_WAIT
  } tsq_fsm_t;

  // Broadcast fan-out, a clock bit and a trigger bit per compare target, one bit per capture or ADC target
  typedef struct packed {
    logic [3:0] adc_trig;
    logic [3:0] capture_trig;
    logic [3:0] compare_clk;
    logic [3:0] compare_trig;
  } tsq_fanout_t;

  typedef struct packed {
    tsq_fsm_t fsm;
    logic [4:0] div;
    logic [15:0] ctrl;
    logic [15:0] bte;
    logic [15:0] hold;
    logic [15:0] adj;
    logic [5:0][15:0] lims;
    logic [4:0] qptr;
    logic [15:0] t0;
    logic [15:0] t1;
    logic [15:0] sd;
    logic [15:0] c0;
    logic [15:0] c1;
    logic sd_en;
    logic wait_t1;
    logic [15:0] rdata;
    logic [5:0] chsel;
    tsq_fanout_t bcast;
    logic [31:0] trig;
    logic busy;
  } tsq_state_t;

endpackage

// *** tsq_regs.sv ***
// Trigger sequencer register set with its step-command execution core
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "tsq_cfg.svh"


module tsq_regs #(
  parameter int SEQ_DIV = `TSQ_SEQ_DIV,
  parameter int QUE_WORDS = 16
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [`TSQ_ADDR_W-1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [15:0] RDATA,
  output tsq_pkg::tsq_fanout_t BCAST_PULSE,
  output logic [31:0] TRIG_OUT,
  output logic [5:0] ADC_CHANNEL_SEL,
  output logic SEQ_BUSY
);

  // ==========================================================
  // Address decode helpers
  function automatic logic is_queue(input logic [`TSQ_ADDR_W-1:0] a);
    is_queue = (a >= `TSQ_A_QUE0) && ({1'b0, a} < 7'(`TSQ_A_QUE0) + 7'(QUE_WORDS));
  endfunction

  // Limit slot for an address; 3'h7 when the address is no limit register
  function automatic logic [2:0] lim_slot(input logic [`TSQ_ADDR_W-1:0] a);
    case (a)
      `TSQ_A_C0LIM: lim_slot = `TSQ_LIM_C0;
      `TSQ_A_C1LIM: lim_slot = `TSQ_LIM_C1;
      `TSQ_A_T0LIM: lim_slot = `TSQ_LIM_T0;
      `TSQ_A_T1LIM: lim_slot = `TSQ_LIM_T1;
      `TSQ_A_SDLIM: lim_slot = `TSQ_LIM_SD;
      `TSQ_A_LIT: lim_slot = `TSQ_LIM_LIT;
      default: lim_slot = 3'h7;
    endcase
  endfunction

  // Registers that freeze while the core runs; hold and literal stay writable
  function automatic logic is_locked(input logic [`TSQ_ADDR_W-1:0] a);
    is_locked = (a == `TSQ_A_BTE) || (a == `TSQ_A_ADJ) || (a == `TSQ_A_QPTR) ||
                is_queue(a) || ((lim_slot(a) != 3'h7) && (a != `TSQ_A_LIT));
  endfunction

  tsq_pkg::tsq_state_t st_r;
  tsq_pkg::tsq_state_t st_nxt;
  logic [15:0] queue_mem [QUE_WORDS];

  logic running;
  logic tick;
  logic exec_now;
  logic [15:0] que_word;
  logic [7:0] step;
  logic [3:0] opc;
  logic [3:0] opt;
  logic [4:0] target;
  logic [4:0] addr_q;
  logic [15:0] live_val;
  logic bcast_go;

  assign running = st_r.ctrl[`TSQ_CTRL_EN] && st_r.ctrl[`TSQ_CTRL_RUN];
  assign tick = (st_r.div == 5'(SEQ_DIV - 1));
  assign exec_now = tick && running && (st_r.fsm == tsq_pkg::TSQ_EXEC);
  assign addr_q = 5'(ADDR - `TSQ_A_QUE0);
  assign que_word = queue_mem[st_r.qptr[4:1]];
  assign step = st_r.qptr[0] ? que_word[15:8] : que_word[7:0];
  assign opc = step[7:4];
  assign opt = step[3:0];
  assign target = {opc[0], opt};
  assign bcast_go = exec_now && (opc == `TSQ_OP_CTRL) && (opt == `TSQ_OPT_BCAST);

  // ==========================================================
  // Step queue: kept out of the reset so a program survives any reset
  always_ff @(posedge CORE_CLK) begin
    if (WR_STB && is_queue(ADDR) && !(running && is_locked(ADDR))) begin
      queue_mem[addr_q[3:0]] <= WDATA;
    end
  end

  // ==========================================================
  // Live value behind a limit address when visibility is on
  always_comb begin
    case (lim_slot(ADDR))
      `TSQ_LIM_C0: live_val = st_r.c0;
      `TSQ_LIM_C1: live_val = st_r.c1;
      `TSQ_LIM_T0: live_val = st_r.t0;
      `TSQ_LIM_T1: live_val = st_r.t1;
      `TSQ_LIM_SD: live_val = st_r.sd;
      default: live_val = st_r.lims[`TSQ_LIM_LIT];
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic [2:0] slot;
    logic step_done;
    slot = lim_slot(ADDR);
    step_done = 1'b0;
    st_nxt = st_r;
    st_nxt.bcast = '0;
    st_nxt.trig = '0;
    st_nxt.rdata = '0;
    st_nxt.div = tick ? 5'h00 : 5'(st_r.div + 5'h01);

    // Software write port
    if (WR_STB && !(running && is_locked(ADDR))) begin
      if (ADDR == `TSQ_A_CTRL) begin
        st_nxt.ctrl = WDATA & `TSQ_CTRL_MASK;
      end else if (ADDR == `TSQ_A_BTE) begin
        st_nxt.bte = WDATA;
      end else if (ADDR == `TSQ_A_HOLD) begin
        st_nxt.hold = WDATA;
      end else if (ADDR == `TSQ_A_ADJ) begin
        st_nxt.adj = WDATA;
      end else if (ADDR == `TSQ_A_QPTR) begin
        st_nxt.qptr = WDATA[4:0];
      end else if (slot != 3'h7) begin
        st_nxt.lims[slot] = WDATA;
      end
    end

    // Software read port, data valid one cycle after the strobe
    if (RD_STB) begin
      if (ADDR == `TSQ_A_CTRL) begin
        st_nxt.rdata = st_r.ctrl;
      end else if (ADDR == `TSQ_A_BTE) begin
        st_nxt.rdata = st_r.bte;
      end else if (ADDR == `TSQ_A_HOLD) begin
        st_nxt.rdata = st_r.hold;
      end else if (ADDR == `TSQ_A_ADJ) begin
        st_nxt.rdata = st_r.adj;
      end else if (ADDR == `TSQ_A_QPTR) begin
        st_nxt.rdata = {11'h000, st_r.qptr};
      end else if (is_queue(ADDR)) begin
        st_nxt.rdata = queue_mem[addr_q[3:0]];
      end else if (slot == `TSQ_LIM_LIT) begin
        st_nxt.rdata = st_r.lims[slot];
      end else if (slot != 3'h7) begin
        st_nxt.rdata = st_r.ctrl[`TSQ_CTRL_VIS] ? live_val : st_r.lims[slot];
      end
    end

    // Execution core, advancing once per sequencer clock
    if (!running) begin
      st_nxt.fsm = tsq_pkg::TSQ_IDLE;
    end else if (tick) begin
      case (st_r.fsm)
        tsq_pkg::TSQ_IDLE: begin
          st_nxt.fsm = tsq_pkg::TSQ_EXEC;
        end
        tsq_pkg::TSQ_EXEC: begin
          step_done = 1'b1;
          st_nxt.qptr = 5'(st_r.qptr + 5'h01);
          if (opc == `TSQ_OP_CTRL) begin
            case (opt)
              `TSQ_OPT_SD_OFF: st_nxt.sd_en = 1'b0;
              `TSQ_OPT_SD_ON: st_nxt.sd_en = 1'b1;
              `TSQ_OPT_WAIT_T0, `TSQ_OPT_WAIT_T1: begin
                step_done = 1'b0;
                st_nxt.wait_t1 = opt[0];
                st_nxt.t0 = '0;
                st_nxt.t1 = '0;
                st_nxt.fsm = tsq_pkg::TSQ_WAIT;
              end
              `TSQ_OPT_CH_C0: st_nxt.chsel = st_r.c0[5:0];
              `TSQ_OPT_CH_C1: st_nxt.chsel = st_r.c1[5:0];
              `TSQ_OPT_CH_LIT: st_nxt.chsel = st_r.lims[`TSQ_LIM_LIT][5:0];
              `TSQ_OPT_BCAST: begin
                st_nxt.bcast.compare_clk = st_r.bte[7:4];
                st_nxt.bcast.compare_trig = st_r.bte[3:0];
                st_nxt.bcast.capture_trig = st_r.bte[11:8];
                st_nxt.bcast.adc_trig = st_r.bte[15:12];
              end
              default: st_nxt.sd_en = st_r.sd_en;
            endcase
          end else if (opc == `TSQ_OP_ADDCOPY) begin
            if (opt[2:0] <= `TSQ_LIM_LIT) begin
              if (opt[3]) begin
                st_nxt.lims[opt[2:0]] = st_r.hold;
              end else begin
                st_nxt.lims[opt[2:0]] = 16'(st_r.lims[opt[2:0]] + st_r.adj);
              end
            end
          end else if (opc[3:1] == `TSQ_OP_STRB) begin
            st_nxt.chsel = {1'b0, target};
          end else if (opc[3:1] == `TSQ_OP_TRIG) begin
            st_nxt.trig[target] = 1'b1;
          end else if (opc[3:1] == `TSQ_OP_JMP) begin
            st_nxt.qptr = target;
          end else if (opc[3:1] == `TSQ_OP_JMPC0) begin
            if (st_r.c0 == st_r.lims[`TSQ_LIM_C0]) begin
              st_nxt.c0 = '0;
            end else begin
              st_nxt.c0 = 16'(st_r.c0 + 16'h0001);
              st_nxt.qptr = target;
            end
          end else if (opc[3:1] == `TSQ_OP_JMPC1) begin
            if (st_r.c1 == st_r.lims[`TSQ_LIM_C1]) begin
              st_nxt.c1 = '0;
            end else begin
              st_nxt.c1 = 16'(st_r.c1 + 16'h0001);
              st_nxt.qptr = target;
            end
          end
        end
        tsq_pkg::TSQ_WAIT: begin
          if (st_r.wait_t1) begin
            if (st_r.t1 == st_r.lims[`TSQ_LIM_T1]) begin
              step_done = 1'b1;
            end else begin
              st_nxt.t1 = 16'(st_r.t1 + 16'h0001);
            end
          end else begin
            if (st_r.t0 == st_r.lims[`TSQ_LIM_T0]) begin
              step_done = 1'b1;
            end else begin
              st_nxt.t0 = 16'(st_r.t0 + 16'h0001);
            end
          end
          if (!step_done) begin
            st_nxt.fsm = tsq_pkg::TSQ_WAIT;
          end
        end
        tsq_pkg::TSQ_DELAY: begin
          if (st_r.sd == st_r.lims[`TSQ_LIM_SD]) begin
            st_nxt.fsm = tsq_pkg::TSQ_EXEC;
          end else begin
            st_nxt.sd = 16'(st_r.sd + 16'h0001);
          end
        end
        default: begin
          st_nxt.fsm = tsq_pkg::TSQ_IDLE;
        end
      endcase
      // The executing clock is the first of the limit+1 delay clocks
      if (step_done) begin
        if (st_r.sd_en && (st_r.lims[`TSQ_LIM_SD] != 16'h0000)) begin
          st_nxt.sd = 16'h0001;
          st_nxt.fsm = tsq_pkg::TSQ_DELAY;
        end else begin
          st_nxt.fsm = tsq_pkg::TSQ_EXEC;
        end
      end
    end
    st_nxt.busy = (st_nxt.fsm != tsq_pkg::TSQ_IDLE);
  end

  // ==========================================================
  // State register
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      st_r <= '0;
      st_r.fsm <= tsq_pkg::TSQ_IDLE;
      st_r.sd_en <= 1'b1;
      st_r.qptr <= `TSQ_RST_QPTR;
      st_r.chsel <= `TSQ_RST_CHSEL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA = st_r.rdata;
  assign BCAST_PULSE = st_r.bcast;
  assign TRIG_OUT = st_r.trig;
  assign ADC_CHANNEL_SEL = st_r.chsel;
  assign SEQ_BUSY = st_r.busy;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  sequence seq_bcast_bit4;
    bcast_go && st_r.bte[4];
  endsequence

  sequence seq_delay_one;
    exec_now && st_r.sd_en && (st_r.lims[`TSQ_LIM_SD] == 16'h0001) &&
      (opc != `TSQ_OP_CTRL || opt[3:1] != 3'h4);
  endsequence

  sequence seq_next_step;
    !exec_now ##1 (exec_now || !running);
  endsequence

  sequence seq_wait_open;
    running && tick && (st_r.fsm == tsq_pkg::TSQ_WAIT);
  endsequence

  sequence seq_jump_c0;
    exec_now && (opc[3:1] == `TSQ_OP_JMPC0);
  endsequence

  sequence seq_jump_c1;
    exec_now && (opc[3:1] == `TSQ_OP_JMPC1);
  endsequence

  AST_BCAST_CLK: assert property (seq_bcast_bit4 |=> BCAST_PULSE.compare_clk[0])
    else $error("compare clock pulse missing on broadcast");
  AST_BCAST_NOCLK: assert property (bcast_go && !st_r.bte[4] |=> !BCAST_PULSE.compare_clk[0])
    else $error("compare clock pulsed with enable clear");
  AST_BCAST_TRG: assert property (bcast_go |=> BCAST_PULSE.compare_trig == $past(st_r.bte[3:0]))
    else $error("compare triggers differ from enable bits");
  AST_BCAST_ONLY: assert property (!bcast_go |=> BCAST_PULSE == '0)
    else $error("broadcast pulse without broadcast command");
  AST_LOCK: assert property (running && WR_STB && ADDR == `TSQ_A_BTE |=> $stable(st_r.bte))
    else $error("broadcast enables changed while running");
  AST_DELAY: assert property ((SEQ_DIV == 1 && running) ##0 seq_delay_one |=> seq_next_step)
    else $error("step delay of limit plus one not kept");
  AST_COPY: assert property (exec_now && opc == `TSQ_OP_ADDCOPY && opt[3] &&
      opt[2:0] <= `TSQ_LIM_LIT |=> st_r.lims[$past(opt[2:0])] == $past(st_r.hold))
    else $error("copy from hold register failed");
  AST_ADD: assert property (exec_now && step == 8'h15 |=>
      st_r.lims[`TSQ_LIM_LIT] == 16'($past(st_r.lims[`TSQ_LIM_LIT]) + $past(st_r.adj)))
    else $error("add to literal failed");
  AST_CHSEL: assert property (exec_now && step == 8'h0e |=>
      ADC_CHANNEL_SEL == $past(st_r.lims[`TSQ_LIM_LIT][5:0]))
    else $error("channel select not loaded from literal");
  AST_QPTR_HI: assert property (RD_STB && ADDR == `TSQ_A_QPTR |=> RDATA[15:5] == 11'h000)
    else $error("pointer upper bits not zero");
  AST_VIS: assert property (RD_STB && ADDR == `TSQ_A_T0LIM && st_r.ctrl[`TSQ_CTRL_VIS] |=>
      RDATA == $past(st_r.t0))
    else $error("live timer 0 value not returned");
  AST_WAIT_T0: assert property (seq_wait_open ##0 (!st_r.wait_t1 &&
      (st_r.t0 != st_r.lims[`TSQ_LIM_T0])) |=> st_r.fsm == tsq_pkg::TSQ_WAIT)
    else $error("timer 0 wait ended before its limit");
  AST_WAIT_T0_END: assert property (seq_wait_open ##0 (!st_r.wait_t1 &&
      (st_r.t0 == st_r.lims[`TSQ_LIM_T0])) |=> st_r.fsm != tsq_pkg::TSQ_WAIT)
    else $error("timer 0 wait outlived its limit");
  AST_WAIT_T1: assert property (seq_wait_open ##0 (st_r.wait_t1 &&
      (st_r.t1 != st_r.lims[`TSQ_LIM_T1])) |=> st_r.fsm == tsq_pkg::TSQ_WAIT)
    else $error("timer 1 wait ended before its limit");
  AST_WAIT_T1_END: assert property (seq_wait_open ##0 (st_r.wait_t1 &&
      (st_r.t1 == st_r.lims[`TSQ_LIM_T1])) |=> st_r.fsm != tsq_pkg::TSQ_WAIT)
    else $error("timer 1 wait outlived its limit");
  AST_LOOP_C0: assert property (seq_jump_c0 ##0 (st_r.c0 != st_r.lims[`TSQ_LIM_C0]) |=>
      st_r.qptr == $past(target) && st_r.c0 == 16'($past(st_r.c0) + 16'h0001))
    else $error("counter 0 loop did not jump back");
  AST_LOOP_C0_END: assert property (seq_jump_c0 ##0 (st_r.c0 == st_r.lims[`TSQ_LIM_C0]) |=>
      st_r.c0 == 16'h0000 && st_r.qptr == 5'($past(st_r.qptr) + 5'h01))
    else $error("counter 0 loop did not fall through");
  AST_LOOP_C1: assert property (seq_jump_c1 ##0 (st_r.c1 != st_r.lims[`TSQ_LIM_C1]) |=>
      st_r.qptr == $past(target) && st_r.c1 == 16'($past(st_r.c1) + 16'h0001))
    else $error("counter 1 loop did not jump back");
  AST_LOOP_C1_END: assert property (seq_jump_c1 ##0 (st_r.c1 == st_r.lims[`TSQ_LIM_C1]) |=>
      st_r.c1 == 16'h0000 && st_r.qptr == 5'($past(st_r.qptr) + 5'h01))
    else $error("counter 1 loop did not fall through");
  AST_LOCK_QPTR: assert property (running && WR_STB && ADDR == `TSQ_A_QPTR &&
      !exec_now |=> $stable(st_r.qptr))
    else $error("queue pointer written while running");
  AST_LOCK_ADJ: assert property (running && WR_STB && ADDR == `TSQ_A_ADJ |=>
      $stable(st_r.adj))
    else $error("adjust register written while running");

endmodule // tsq_regs

// *** tsq_trig_sink.sv ***
// Model of the compare, capture and ADC trigger inputs fed by the sequencer
`timescale 1ns/1ps
module tsq_trig_sink (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] bcast,
  input wire logic [31:0] trig,
  input wire logic [5:0] chsel,
  output logic ev_valid,
  output logic [53:0] ev_data
);
  logic [5:0] chsel_r;

  // ==========================================================
  // Channel select is a level, so only a change of it is an event
  always_ff @(posedge clk) begin
    if (!resetn) begin
      chsel_r <= 6'h00;
    end else begin
      chsel_r <= chsel;
    end
  end

  assign ev_valid = resetn && ((bcast != 16'h0000) || (trig != 32'h00000000) ||
                    (chsel != chsel_r));
  assign ev_data = {bcast, trig, chsel};
endmodule // tsq_trig_sink
